//--- common/ssr_pkg.sv
// Package of offsets, field positions, encodings and types for the sleep configuration bank.
package ssr_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_KEEP_UPPER = 8'h28;
    localparam logic [7:0] OFF_FORCE_REGS = 8'h29;
    localparam logic [7:0] OFF_FORCE_MISC = 8'h2a;
    localparam logic [7:0] OFF_VOLT_SEL   = 8'h2b;

    // ----------------------------------------------------------------
    // Field positions and masks
    // ----------------------------------------------------------------
    localparam int          KEEP_REG9_BIT   = 0;
    localparam int          KEEP_BUCK1_BIT  = 2;
    localparam int          MISC_REG9_BIT   = 0;
    localparam int          MISC_BUCK1_BIT  = 2;
    localparam int          CLK_OUT_BIT     = 6;
    localparam int          THERM_BIT       = 7;
    localparam logic [7:0]  KEEP_UPPER_MASK = 8'h3f;

    // ----------------------------------------------------------------
    // Values after reset, before the fuse defaults are loaded
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_RESET_VAL   = 8'h00;

    // ----------------------------------------------------------------
    // Resource state encoding
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SSR_ACTIVE    = 2'h0,
        SSR_LOW_POWER = 2'h1,
        SSR_OFF       = 2'h2
    } ssr_res_mode_t;

    typedef enum logic [2:0] {
        SSR_LOAD   = 3'h1,
        SSR_AWAKE  = 3'h2,
        SSR_ASLEEP = 3'h4
    } ssr_fsm_t;

    typedef struct packed {
        logic [7:0] keep_upper;
        logic [7:0] force_regs;
        logic [7:0] force_misc;
        logic [7:0] volt_sel;
    } ssr_fuse_t;

    typedef struct packed {
        ssr_fsm_t           fsm;
        ssr_fuse_t          regs;
        logic [7:0]         rd_data;
        logic               sleep_meta;
        logic               sleep_sync;
        logic               sleep_sync_ok;
        ssr_res_mode_t [3:0] buck_mode;
        ssr_res_mode_t [9:0] reg_mode;
        logic               thermal_on;
        logic               clk_out_on;
        logic [7:0]         voltage_register_select;
        logic               asleep;
    } ssr_state_t;

endpackage

//--- sim/ssr_sleep_config_sva.sv
// Assertion checker for the sleep configuration bank, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module ssr_sleep_config_sva (
    input wire logic                         clk,
    input wire logic                         rst_b,
    input wire logic                         reg_wr_en,
    input wire logic [7:0]                   reg_addr,
    input wire logic [7:0]                   reg_wr_data,
    input wire logic [7:0]                   regulator_sleep_keep_low,
    input wire logic [3:0]                   buck_forced_mode,
    input wire logic                         sleep_enable,
    input wire logic                         sleep_polarity_low,
    input wire logic                         irq_pending,
    input wire logic                         sleep_pin,
    input wire ssr_pkg::ssr_res_mode_t [3:0] buck_mode,
    input wire ssr_pkg::ssr_res_mode_t [9:0] regulator_mode,
    input wire logic                         thermal_monitor_on,
    input wire logic                         slow_clock_out_on,
    input wire logic [7:0]                   voltage_register_select,
    input wire logic                         sleep_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Six cycles covers the four-edge pin path with margin, so no race with the synchroniser.
    wire req = sleep_enable && !irq_pending && (sleep_pin ^ sleep_polarity_low);
    sequence s_req_held; req [*6]; endsequence
    sequence s_idle_held; !req [*6]; endsequence
    property p_enter; s_req_held |-> sleep_active; endproperty
    property p_idle; s_idle_held |-> !sleep_active; endproperty
    property p_awake; !sleep_active |-> buck_mode == 8'h00 && regulator_mode == 20'h00000; endproperty
    property p_aux; !sleep_active |-> thermal_monitor_on && slow_clock_out_on; endproperty
    property p_keep; sleep_active && $past(regulator_sleep_keep_low[0])
        |-> regulator_mode[0] == ssr_pkg::SSR_ACTIVE; endproperty
    property p_nokeep; sleep_active && !$past(regulator_sleep_keep_low[1])
        |-> regulator_mode[1] != ssr_pkg::SSR_ACTIVE; endproperty
    property p_forced; sleep_active && $past(buck_forced_mode[0])
        |-> buck_mode[0] != ssr_pkg::SSR_LOW_POWER; endproperty
    property p_volt; reg_wr_en && reg_addr == ssr_pkg::OFF_VOLT_SEL
        |-> ##2 voltage_register_select == $past(reg_wr_data, 2); endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered");
    a_idle: assert property (p_idle) else $error("sleep without request");
    a_awake: assert property (p_awake) else $error("resource not active when awake");
    a_aux: assert property (p_aux) else $error("aux function off when awake");
    a_keep: assert property (p_keep) else $error("kept regulator not active");
    a_nokeep: assert property (p_nokeep) else $error("unkept regulator active");
    a_forced: assert property (p_forced) else $error("forced buck in low power");
    a_volt: assert property (p_volt) else $error("voltage select mismatch");
endmodule
bind ssr_sleep_config ssr_sleep_config_sva u_sva (.clk, .rst_b, .reg_wr_en, .reg_addr,
    .reg_wr_data, .regulator_sleep_keep_low, .buck_forced_mode, .sleep_enable,
    .sleep_polarity_low, .irq_pending, .sleep_pin, .buck_mode, .regulator_mode,
    .thermal_monitor_on, .slow_clock_out_on, .voltage_register_select, .sleep_active);
`default_nettype wire

//--- sim/tb.sv
// Self-checking testbench for the sleep configuration bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                         clk = 1'b0;
    logic                         rst_b = 1'b0;
    ssr_pkg::ssr_fuse_t           fuse_defaults = 32'hffa53c5a;
    logic                         reg_wr_en = 1'b0;
    logic                         reg_rd_en = 1'b0;
    logic [7:0]                   reg_addr = 8'h00;
    logic [7:0]                   reg_wr_data = 8'h00;
    logic [7:0]                   reg_rd_data;
    logic [7:0]                   regulator_sleep_keep_low = 8'h0d;
    logic [3:0]                   buck_forced_mode = 4'h7;
    logic                         sleep_enable = 1'b0;
    logic                         sleep_polarity_low = 1'b0;
    logic                         irq_pending = 1'b0;
    logic                         sleep_pin = 1'b0;
    ssr_pkg::ssr_res_mode_t [3:0] buck_mode;
    ssr_pkg::ssr_res_mode_t [9:0] regulator_mode;
    logic                         thermal_monitor_on;
    logic                         slow_clock_out_on;
    logic [7:0]                   voltage_register_select;
    logic                         sleep_active;
    int                           checks = 0;
    int                           miscompares = 0;
    ssr_sleep_config dut (.clk, .rst_b, .fuse_defaults, .reg_wr_en, .reg_rd_en, .reg_addr,
        .reg_wr_data, .reg_rd_data, .regulator_sleep_keep_low, .buck_forced_mode, .sleep_enable,
        .sleep_polarity_low, .irq_pending, .sleep_pin, .buck_mode, .regulator_mode,
        .thermal_monitor_on, .slow_clock_out_on, .voltage_register_select, .sleep_active);
    always #50 clk = ~clk;
    task automatic cmp(input string n, input logic [19:0] e, input logic [19:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // One strobe per call; reads are judged on the byte that comes back.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr_en = w;
        reg_rd_en = !w;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        if (!w)
            cmp("rd_data", {12'h0, d}, {12'h0, reg_rd_data});
    endtask
    task automatic outs(input logic [7:0] b, input logic [19:0] r, input logic [2:0] x);
        repeat (6) @(negedge clk);
        cmp("buck_mode", {12'h0, b}, {12'h0, buck_mode});
        cmp("regulator_mode", r, regulator_mode);
        cmp("aux_sleep", {17'h0, x}, {17'h0, thermal_monitor_on, slow_clock_out_on, sleep_active});
    endtask
    task automatic t_reset;
        rst_b = 1'b0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (4)
        begin
            @(negedge clk);
            cmp("sleep_after_reset", 20'h00000, {19'h0, sleep_active});
        end
        bus(1'b0, ssr_pkg::OFF_KEEP_UPPER, 8'h3f);
        bus(1'b0, ssr_pkg::OFF_FORCE_REGS, 8'ha5);
        bus(1'b0, ssr_pkg::OFF_FORCE_MISC, 8'h3c);
        bus(1'b0, ssr_pkg::OFF_VOLT_SEL, 8'h5a);
        bus(1'b0, 8'h2c, 8'h00);
        cmp("volt_out", 20'h0005a, {12'h0, voltage_register_select});
        $display("test reset done");
    endtask
    task automatic t_sleep;
        bus(1'b1, ssr_pkg::OFF_KEEP_UPPER, 8'hc5);
        bus(1'b0, ssr_pkg::OFF_KEEP_UPPER, 8'h05);
        bus(1'b1, ssr_pkg::OFF_FORCE_REGS, 8'h30);
        bus(1'b1, ssr_pkg::OFF_FORCE_MISC, 8'h8c);
        bus(1'b1, ssr_pkg::OFF_VOLT_SEL, 8'ha3);
        bus(1'b0, ssr_pkg::OFF_VOLT_SEL, 8'ha3);
        cmp("volt_out", 20'h000a3, {12'h0, voltage_register_select});
        sleep_polarity_low = 1'b1;
        sleep_enable = 1'b1;
        outs(8'h48, 20'h45a04, 3'b011);
        irq_pending = 1'b1;
        outs(8'h00, 20'h00000, 3'b110);
        bus(1'b1, ssr_pkg::OFF_FORCE_MISC, 8'h4c);
        irq_pending = 1'b0;
        outs(8'h48, 20'h45a04, 3'b101);
        sleep_pin = 1'b1;
        outs(8'h00, 20'h00000, 3'b110);
        $display("test sleep done");
    endtask
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        t_reset;
        t_sleep;
        t_reset;
        wrap_up;
    end
    // About eighty cycles of work, so two thousand cycles means a hang.
    initial
    begin
        #200000;
        miscompares++;
        wrap_up;
    end
endmodule
`default_nettype wire

//--- src/ssr_sleep_config.sv
// Sleep-state resource configuration bank and resource state decode.
//
// Functional notes
// - Buck with keep bit 0 goes low-power in sleep, unless its off bit or its forced-mode bit is 1.
// - Keep bit 1 holds the resource fully active in sleep, ignoring its off bit.
// - Regulators 9 and 10 with keep bit 0 go low-power in sleep unless off bit set.
// - Off bit 0 leaves the sleep behaviour to the keep bit, plus the forced-mode bit for a buck.
// - Off bit 1 with keep bit 0 turns the resource fully off in sleep.
// - Thermal monitor bit 7 and clock-out bit 6: 0 stays on in sleep, 1 off.
// - Every reset reloads all four registers from their fuse defaults; keep register bits 7:6 always load as 0.
// - Voltage select bit 0 uses the operating register, 1 the scaling register.
// - Sleep applies only when enabled, no interrupt pending, sleep pin active at polarity.
`timescale 1ns/1ps
`default_nettype none

module ssr_sleep_config (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire ssr_pkg::ssr_fuse_t    fuse_defaults,
    input  wire logic                  reg_wr_en,
    input  wire logic                  reg_rd_en,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wr_data,
    output logic [7:0]                 reg_rd_data,
    input  wire logic [7:0]            regulator_sleep_keep_low,
    input  wire logic [3:0]            buck_forced_mode,
    input  wire logic                  sleep_enable,
    input  wire logic                  sleep_polarity_low,
    input  wire logic                  irq_pending,
    input  wire logic                  sleep_pin,
    output ssr_pkg::ssr_res_mode_t [3:0] buck_mode,
    output ssr_pkg::ssr_res_mode_t [9:0] regulator_mode,
    output logic                       thermal_monitor_on,
    output logic                       slow_clock_out_on,
    output logic [7:0]                 voltage_register_select,
    output logic                       sleep_active
);

    // ----------------------------------------------------------------
    // Sleep decode for one resource
    // ----------------------------------------------------------------
    function automatic ssr_pkg::ssr_res_mode_t res_mode(
        input logic asleep,
        input logic keep,
        input logic off,
        input logic hold_active
    );
        ssr_pkg::ssr_res_mode_t m;
        m = ssr_pkg::SSR_ACTIVE;
        if (asleep && !keep)
        begin
            if (off)
                m = ssr_pkg::SSR_OFF;
            else if (!hold_active)
                m = ssr_pkg::SSR_LOW_POWER;
        end
        return m;
    endfunction

    ssr_pkg::ssr_state_t st_reg;
    ssr_pkg::ssr_state_t st_next;
    logic                sleep_req;
    logic [9:0]          keep_all;
    logic [9:0]          off_all;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next            = st_reg;
        st_next.sleep_meta = sleep_pin;
        st_next.sleep_sync = st_reg.sleep_meta;
        // Both synchroniser flops leave reset at 0, which an active-low pin would read as a
        // request; entry waits until the second flop holds a real pin sample.
        st_next.sleep_sync_ok = (st_reg.fsm != ssr_pkg::SSR_LOAD);
        sleep_req = sleep_enable && !irq_pending
                    && (st_reg.sleep_sync ^ sleep_polarity_low);
        keep_all = {st_reg.regs.keep_upper[1:0], regulator_sleep_keep_low};
        off_all  = {st_reg.regs.force_misc[1:0], st_reg.regs.force_regs};

        case (st_reg.fsm)
            ssr_pkg::SSR_LOAD:
            begin
                // Fuse values are sampled after release so the flops stay constant under reset.
                st_next.regs            = fuse_defaults;
                st_next.regs.keep_upper = fuse_defaults.keep_upper & ssr_pkg::KEEP_UPPER_MASK;
                st_next.fsm             = ssr_pkg::SSR_AWAKE;
            end
            ssr_pkg::SSR_AWAKE:
            begin
                if (sleep_req && st_reg.sleep_sync_ok)
                    st_next.fsm = ssr_pkg::SSR_ASLEEP;
            end
            ssr_pkg::SSR_ASLEEP:
            begin
                if (!sleep_req)
                    st_next.fsm = ssr_pkg::SSR_AWAKE;
            end
            default:
                st_next.fsm = ssr_pkg::SSR_LOAD;
        endcase

        if (reg_wr_en && st_reg.fsm != ssr_pkg::SSR_LOAD)
        begin
            case (reg_addr)
                ssr_pkg::OFF_KEEP_UPPER:
                    st_next.regs.keep_upper = reg_wr_data & ssr_pkg::KEEP_UPPER_MASK;
                ssr_pkg::OFF_FORCE_REGS: st_next.regs.force_regs = reg_wr_data;
                ssr_pkg::OFF_FORCE_MISC: st_next.regs.force_misc = reg_wr_data;
                ssr_pkg::OFF_VOLT_SEL:   st_next.regs.volt_sel   = reg_wr_data;
                default: ;
            endcase
        end

        if (reg_rd_en)
        begin
            case (reg_addr)
                ssr_pkg::OFF_KEEP_UPPER: st_next.rd_data = st_reg.regs.keep_upper;
                ssr_pkg::OFF_FORCE_REGS: st_next.rd_data = st_reg.regs.force_regs;
                ssr_pkg::OFF_FORCE_MISC: st_next.rd_data = st_reg.regs.force_misc;
                ssr_pkg::OFF_VOLT_SEL:   st_next.rd_data = st_reg.regs.volt_sel;
                default:                 st_next.rd_data = 8'h00;
            endcase
        end

        // Outputs follow the registered state, so they lag a mode change by one cycle.
        st_next.asleep = (st_reg.fsm == ssr_pkg::SSR_ASLEEP);
        for (int i = 0; i < 4; i++)
        begin
            st_next.buck_mode[i] = res_mode(st_next.asleep,
                                            st_reg.regs.keep_upper[ssr_pkg::KEEP_BUCK1_BIT + i],
                                            st_reg.regs.force_misc[ssr_pkg::MISC_BUCK1_BIT + i],
                                            buck_forced_mode[i]);
        end
        for (int i = 0; i < 10; i++)
        begin
            st_next.reg_mode[i] = res_mode(st_next.asleep, keep_all[i], off_all[i],
                                           1'b0);
        end
        st_next.thermal_on = !(st_next.asleep
                               && st_reg.regs.force_misc[ssr_pkg::THERM_BIT]);
        st_next.clk_out_on = !(st_next.asleep
                               && st_reg.regs.force_misc[ssr_pkg::CLK_OUT_BIT]);
        st_next.voltage_register_select = st_reg.regs.volt_sel;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg                         <= '0;
            st_reg.fsm                     <= ssr_pkg::SSR_LOAD;
            st_reg.regs.keep_upper         <= ssr_pkg::REG_RESET_VAL;
            st_reg.regs.force_regs         <= ssr_pkg::REG_RESET_VAL;
            st_reg.regs.force_misc         <= ssr_pkg::REG_RESET_VAL;
            st_reg.regs.volt_sel           <= ssr_pkg::REG_RESET_VAL;
            st_reg.thermal_on              <= 1'b1;
            st_reg.clk_out_on              <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rd_data             = st_reg.rd_data;
    assign buck_mode               = st_reg.buck_mode;
    assign regulator_mode          = st_reg.reg_mode;
    assign thermal_monitor_on      = st_reg.thermal_on;
    assign slow_clock_out_on       = st_reg.clk_out_on;
    assign voltage_register_select = st_reg.voltage_register_select;
    assign sleep_active            = st_reg.asleep;

endmodule

`default_nettype wire
